// ### verilog/spi_cmd_pkg.sv
package spi_cmd_pkg;
	// word layout
	localparam int        WORD_W      = 16;
	localparam int        OP_HI       = 15;
	localparam int        OP_LO       = 13;
	localparam int        BCAST_BIT   = 12;
	localparam int        HW_ADDR_HI  = 11;
	localparam int        HW_ADDR_LO  = 8;
	localparam int        FIELD_HI    = 7;
	localparam int        HALF_HI     = 15;
	localparam int        HOLD_HI     = 31;
	localparam int        HALF_LO_TOP = 16;
	localparam logic [4:0] BIT_COUNT  = 5'h10;
	// op codes in bits 15..13; bit 15 clear is a no-op
	localparam logic [2:0] OP_SETADR  = 3'h4;
	localparam logic [2:0] OP_WRITE   = 3'h5;
	localparam logic [2:0] OP_RDLO    = 3'h6;
	localparam logic [2:0] OP_RDHI    = 3'h7;
	// reset values and counts
	localparam logic [3:0] HW_ADDR_RESET = 4'h0;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam logic [6:0] OFF_ZERO     = 7'h00;
	localparam logic [6:0] OFF_STEP     = 7'h01;
	localparam logic [4:0] CNT_STEP     = 5'h01;
	localparam logic [1:0] BOOT_STEP    = 2'h1;

	typedef enum logic [1:0] {OUT_NONE, OUT_LOW, OUT_HIGH} out_sel_t;
	typedef enum logic [1:0] {CAP_IDLE, CAP_NOW, CAP_SYNC} cap_state_t;
endpackage

// ### verilog/spi_slave_register_access.sv
`timescale 1ns/100ps
// Functional notes
// - SPI enabled only if serial select is high at the second ref_clk edge after reset release
// - mode 0, 16-bit words, MSB first, clock idles low
// - bits taken only with select low; MISO floats or waits; execute on select rise
// - MOSI sampled on rising SCK, MISO changed on falling SCK
// - MISO held low in reset and while synchronous read waits
// - word is 3-bit op code, broadcast flag, 4-bit hardware address, 8-bit field
// - 100 set address, 101 write, 110 read low, 111 read high, bit15=0 no-op
// - broadcast flag low makes every device execute set address and write, address ignored
// - read low accepted only on own hardware address, reset zero, set address and write also on broadcast; read high on any
// - latch-strap command copies four strap pins into hardware address
// - read data shifts out during next word, whatever its address
// - read low loads 32-bit holding register, low half returned next word
// - after read high, upper half returned during next word
// - write is set address then write data, one byte per write
// - synchronous mode captures at sample point shifted by sample offset
// - immediate capture loads holding register right after select rise
// - device is slave only, host word starts every transaction
module spi_slave_register_access
	import spi_cmd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        serial_select_n,
	output logic             miso_out,
	output logic             miso_oe,
	input  wire logic [3:0]  strap_select_pins,
	input  wire logic        latch_strap_command,
	input  wire logic        immediate_capture,
	input  wire logic [6:0]  sample_offset,
	input  wire logic        sample_strobe,
	input  wire logic [31:0] rd_data,
	output logic [7:0]       rd_addr,
	output logic             rd_capture,
	output logic [7:0]       reg_addr,
	output logic [7:0]       wr_data,
	output logic             wr_en,
	output logic [3:0]       hw_addr,
	output logic             spi_enabled
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic       sck_s1, sck_s2, sck_d;
	logic       mosi_s1, mosi_s2;
	logic       ssn_s1, ssn_s2, ssn_d;
	logic [3:0] strap_s1, strap_s2;

	// two flops per pin, a third only for edge finding
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1   <= 1'b0;
			sck_s2   <= 1'b0;
			sck_d    <= 1'b0;
			mosi_s1  <= 1'b0;
			mosi_s2  <= 1'b0;
			ssn_s1   <= 1'b1;
			ssn_s2   <= 1'b1;
			ssn_d    <= 1'b1;
			strap_s1 <= HW_ADDR_RESET;
			strap_s2 <= HW_ADDR_RESET;
		end else begin
			sck_s1   <= sck;
			sck_s2   <= sck_s1;
			sck_d    <= sck_s2;
			mosi_s1  <= mosi;
			mosi_s2  <= mosi_s1;
			ssn_s1   <= serial_select_n;
			ssn_s2   <= ssn_s1;
			ssn_d    <= ssn_s2;
			strap_s1 <= strap_select_pins;
			strap_s2 <= strap_s1;
		end
	end

	logic sck_rise, sck_fall, ss_fall, ss_rise;
	assign sck_rise = sck_s2 & ~sck_d;
	assign sck_fall = ~sck_s2 & sck_d;
	assign ss_fall  = ~ssn_s2 & ssn_d;
	assign ss_rise  = ssn_s2 & ~ssn_d;

	////////////////////////////////////////////////////////////////////////
	// main state
	logic [1:0]  boot_cnt, next_boot_cnt;
	logic        booted, next_booted;
	logic        next_spi_enabled;
	logic [15:0] shift_in, next_shift_in;
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [15:0] out_shift, next_out_shift;
	logic        next_miso_out, next_miso_oe;
	logic [3:0]  next_hw_addr;
	logic [7:0]  next_reg_addr, next_wr_data, next_rd_addr;
	logic        next_wr_en, next_rd_capture;
	logic [31:0] hold, next_hold;
	out_sel_t    out_sel, next_out_sel;
	cap_state_t  cap_state, next_cap_state;
	logic [6:0]  off_cnt, next_off_cnt;
	logic        off_run, next_off_run;

	// word decode helpers
	logic [2:0]  op;
	logic        word_ok, addr_ok, bcast, acc_wr, acc_rd, sample_hit;
	logic [15:0] out_load;
	assign op         = shift_in[OP_HI:OP_LO];
	assign word_ok    = ss_rise && bit_cnt == BIT_COUNT;
	assign addr_ok    = shift_in[HW_ADDR_HI:HW_ADDR_LO] == hw_addr;
	assign bcast      = ~shift_in[BCAST_BIT];
	assign acc_wr     = word_ok && (bcast || addr_ok);
	assign acc_rd     = word_ok && addr_ok;
	assign sample_hit = off_run && off_cnt == sample_offset;

	// next word's first bits: holding halves, or zero while not ready
	always_comb begin
		case (out_sel)
			OUT_LOW:  out_load = hold[HALF_HI:0];
			OUT_HIGH: out_load = hold[HOLD_HI:HALF_LO_TOP];
			default:  out_load = '0;
		endcase
		if (cap_state != CAP_IDLE) begin
			out_load = '0;
		end
	end

	// next-value logic for all control state
	always_comb begin
		next_boot_cnt    = boot_cnt;
		next_booted      = booted;
		next_spi_enabled = spi_enabled;
		next_shift_in    = shift_in;
		next_bit_cnt     = bit_cnt;
		next_out_shift   = out_shift;
		next_miso_out    = miso_out;
		next_miso_oe     = miso_oe;
		next_hw_addr     = hw_addr;
		next_reg_addr    = reg_addr;
		next_wr_data     = wr_data;
		next_rd_addr     = rd_addr;
		next_wr_en       = 1'b0;
		next_rd_capture  = 1'b0;
		next_hold        = hold;
		next_out_sel     = out_sel;
		next_cap_state   = cap_state;
		next_off_cnt     = off_cnt;
		next_off_run     = off_run;

		// strap is caught once the synchroniser has settled after release
		if (!booted) begin
			next_boot_cnt = boot_cnt + BOOT_STEP;
			if (boot_cnt == STRAP_SETTLE) begin
				next_booted      = 1'b1;
				next_spi_enabled = ssn_s2;
			end
		end

		if (latch_strap_command) begin
			next_hw_addr = strap_s2;
		end

		// sample-point offset counter, restarted on every sequence strobe
		if (sample_strobe) begin
			next_off_cnt = OFF_ZERO;
			next_off_run = 1'b1;
		end else if (off_run) begin
			if (sample_hit) begin
				next_off_run = 1'b0;
			end else begin
				next_off_cnt = off_cnt + OFF_STEP;
			end
		end

		// holding register is written only here
		case (cap_state)
			CAP_NOW: begin
				next_hold       = rd_data;
				next_rd_capture = 1'b1;
				next_cap_state  = CAP_IDLE;
			end
			CAP_SYNC: begin
				if (sample_hit) begin
					next_hold       = rd_data;
					next_rd_capture = 1'b1;
					next_cap_state  = CAP_IDLE;
				end
			end
			default: begin
				next_hold = hold;
			end
		endcase

		if (booted && spi_enabled) begin
			// bit transfer only while select is low
			if (ss_fall) begin
				next_bit_cnt   = '0;
				next_out_shift = out_load;
				next_miso_out  = out_load[HALF_HI];
			end else if (!ssn_s2) begin
				if (sck_rise) begin
					next_shift_in = {shift_in[HALF_HI-1:0], mosi_s2};
					if (bit_cnt != BIT_COUNT) begin
						next_bit_cnt = bit_cnt + CNT_STEP;
					end
				end
				if (sck_fall) begin
					next_out_shift = {out_shift[HALF_HI-1:0], 1'b0};
					next_miso_out  = out_shift[HALF_HI-1];
				end
			end

			// only a complete host word acts; nothing starts on its own
			if (word_ok) begin
				next_out_sel = OUT_NONE;
				if (shift_in[OP_HI]) begin
					case (op)
						OP_SETADR: begin
							if (acc_wr) begin
								next_reg_addr = shift_in[FIELD_HI:0];
							end
						end
						OP_WRITE: begin
							if (acc_wr) begin
								next_wr_data = shift_in[FIELD_HI:0];
								next_wr_en   = 1'b1;
							end
						end
						OP_RDLO: begin
							if (acc_rd) begin
								next_rd_addr = shift_in[FIELD_HI:0];
								next_out_sel = OUT_LOW;
								next_cap_state = immediate_capture ? CAP_NOW : CAP_SYNC;
							end
						end
						OP_RDHI: begin
							next_out_sel = OUT_HIGH;
						end
						default: begin
							next_out_sel = OUT_NONE;
						end
					endcase
				end
			end

			// idle select: release, or pull low while a capture waits
			if (ssn_s2) begin
				next_miso_out = 1'b0;
				next_miso_oe  = next_cap_state == CAP_SYNC;
			end else begin
				next_miso_oe  = 1'b1;
			end
		end else if (booted) begin
			next_miso_out = 1'b0;
			next_miso_oe  = 1'b0;
		end
	end

	// register stage; reset drives MISO low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt    <= '0;
			booted      <= 1'b0;
			spi_enabled <= 1'b0;
			shift_in    <= '0;
			bit_cnt     <= '0;
			out_shift   <= '0;
			miso_out    <= 1'b0;
			miso_oe     <= 1'b1;
			hw_addr     <= HW_ADDR_RESET;
			reg_addr    <= '0;
			wr_data     <= '0;
			rd_addr     <= '0;
			wr_en       <= 1'b0;
			rd_capture  <= 1'b0;
			hold        <= '0;
			out_sel     <= OUT_NONE;
			cap_state   <= CAP_IDLE;
			off_cnt     <= OFF_ZERO;
			off_run     <= 1'b0;
		end else begin
			boot_cnt    <= next_boot_cnt;
			booted      <= next_booted;
			spi_enabled <= next_spi_enabled;
			shift_in    <= next_shift_in;
			bit_cnt     <= next_bit_cnt;
			out_shift   <= next_out_shift;
			miso_out    <= next_miso_out;
			miso_oe     <= next_miso_oe;
			hw_addr     <= next_hw_addr;
			reg_addr    <= next_reg_addr;
			wr_data     <= next_wr_data;
			rd_addr     <= next_rd_addr;
			wr_en       <= next_wr_en;
			rd_capture  <= next_rd_capture;
			hold        <= next_hold;
			out_sel     <= next_out_sel;
			cap_state   <= next_cap_state;
			off_cnt     <= next_off_cnt;
			off_run     <= next_off_run;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_strap_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(booted) |-> spi_enabled == $past(ssn_s2))
		else $error("enable does not follow strapped select level");
	chk_idle_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		booted && ssn_s2 && next_cap_state != CAP_SYNC |=> !miso_oe)
		else $error("miso driven while deselected and ready");
	chk_miso_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
		booted && !ssn_d && $changed(miso_out) |-> $past(sck_fall || ss_fall))
		else $error("miso changed without falling sck");
	chk_wait_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		spi_enabled && cap_state == CAP_SYNC && ssn_d |-> miso_oe && !miso_out)
		else $error("miso not held low during wait");
	chk_write_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
		spi_enabled && acc_wr && shift_in[OP_HI] && op == OP_WRITE
		|=> wr_en && wr_data == $past(shift_in[FIELD_HI:0]))
		else $error("accepted write not issued");
	chk_foreign_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		word_ok && !bcast && !addr_ok |=> !wr_en)
		else $error("write taken for other hardware address");
	chk_strap_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		latch_strap_command |=> hw_addr == $past(strap_s2))
		else $error("strap pins not latched");
	chk_immediate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		spi_enabled && acc_rd && op == OP_RDLO && immediate_capture |-> ##2 rd_capture)
		else $error("immediate capture late");
	chk_hold_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$changed(hold) |-> rd_capture)
		else $error("holding register changed without capture");

endmodule

// ### tb/spi_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// host end of the link: mode 0 master, one word per call
module spi_host_model (
	output logic      sck,
	output logic      mosi,
	output logic      serial_select_n,
	input  wire logic miso
);
	// idle: clock low, select high, host never starts on its own
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		serial_select_n = 1'b1;
	end
	// msb first, data set before each rise, read bit taken on the rise
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#2; // step off the sampling edge of the block's clock
		serial_select_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = w[i];
			#80 sck = 1'b1;
			r[i] = miso;
			#80 sck = 1'b0;
		end
		#80 serial_select_n = 1'b1;
		mosi = ~mosi; // released line shows no stale bit
		#238; // keeps each call a whole number of clock periods
	endtask
endmodule

// ### tb/tb_spi_slave_register_access.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb_spi_slave_register_access;
	import spi_cmd_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        latch = 1'b0;
	logic        imm = 1'b1;
	logic        strobe = 1'b0;
	logic [6:0]  offset = 7'h40;
	logic [3:0]  straps = 4'h0;
	logic [3:0]  hw = 4'h0;
	logic [31:0] xs = 32'he5ff;
	logic [31:0] v, e;
	logic [15:0] r, wr_seen;
	logic [7:0]  rd_addr, reg_addr, wr_data, a;
	logic [3:0]  hw_addr;
	logic        sck, mosi, ssn, miso_out, miso_oe, rd_capture, wr_en, spi_enabled;
	wire         miso_w;
	wire  [31:0] rd_data_w;
	int          n_wr = 0, t_cyc = 0, t_strobe = 0, t_gap = 0;
	int          n_mismatch = 0, checks_done = 0;

	always #10 ref_clk = ~ref_clk;
	assign miso_w = miso_oe ? miso_out : 1'b1; // pull-up when released

	// register file seen by the block
	function automatic logic [31:0] regval(input logic [7:0] ad);
		return {~ad, ad, ad ^ 8'h5a, 8'hc3};
	endfunction
	function automatic logic [31:0] rnd();
		xs ^= xs << 13;
		xs ^= xs >> 17;
		xs ^= xs << 5;
		return xs;
	endfunction
	assign rd_data_w = regval(rd_addr); // register file answers the read address

	spi_host_model spi_host_model_i (.sck(sck), .mosi(mosi), .serial_select_n(ssn),
		.miso(miso_w));
	spi_slave_register_access spi_slave_register_access_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.sck(sck), .mosi(mosi), .serial_select_n(ssn), .miso_out(miso_out),
		.miso_oe(miso_oe), .strap_select_pins(straps), .latch_strap_command(latch),
		.immediate_capture(imm), .sample_offset(offset), .sample_strobe(strobe),
		.rd_data(rd_data_w), .rd_addr(rd_addr), .rd_capture(rd_capture),
		.reg_addr(reg_addr), .wr_data(wr_data), .wr_en(wr_en), .hw_addr(hw_addr),
		.spi_enabled(spi_enabled));

	// sampling sequence and observation of writes and captures
	always @(posedge ref_clk) begin
		t_cyc <= t_cyc + 1;
		strobe <= (t_cyc % 100 == 0);
		if (strobe) t_strobe <= t_cyc;
		if (rd_capture === 1'b1) t_gap <= t_cyc - t_strobe;
		if (wr_en === 1'b1) begin
			wr_seen <= {reg_addr, wr_data};
			n_wr <= n_wr + 1;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// set address then write one byte; ok says whether the block should take it
	task automatic wr(input logic [3:0] h, input logic bcast_n, input logic [7:0] ad,
		input logic [7:0] dt, input int ok);
		int n0;
		n0 = n_wr;
		spi_host_model_i.xfer({OP_SETADR, bcast_n, h, ad}, r);
		spi_host_model_i.xfer({OP_WRITE, bcast_n, h, dt}, r);
		chk(n_wr - n0, ok);
		if (ok) chk(wr_seen, {ad, dt});
	endtask
	// read-low; in synchronous mode wait for the not-ready low to end
	task automatic rdlo(input logic [7:0] ad);
		while (t_cyc % 100 != 50) @(posedge ref_clk);
		spi_host_model_i.xfer({OP_RDLO, 1'b1, hw, ad}, r);
		if (!imm) begin
			chk(miso_w, 1'b0);
			for (int k = 0; k < 300 && miso_w !== 1'b1; k++) @(posedge ref_clk);
			chk(miso_w, 1'b1);
			// capture lands offset+1 edges after the strobe is taken, seen one edge later
			@(posedge ref_clk);
			chk(t_gap, offset + 2);
		end
	endtask
	task automatic rdword(input logic [15:0] w, input logic [15:0] exp);
		spi_host_model_i.xfer(w, r);
		chk(r, exp);
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		chk({miso_oe, miso_out}, 2'b10);
		chk(hw_addr, HW_ADDR_RESET);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(spi_enabled, 1'b1);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			wr(4'h0, 1'b1, (v[7:0] & 8'hfc) | 8'(i), v[15:8], 1);
			wr(v[19:16] | 4'h1, 1'b0, v[27:20], v[31:24], 1);
			wr(v[19:16] | 4'h1, 1'b1, v[27:20], v[31:24], 0);
		end
		v = rnd();
		@(posedge ref_clk) straps <= v[3:0] | 4'h1;
		// let the strap synchroniser settle before the latch pulse
		repeat (3) @(posedge ref_clk);
		latch <= 1'b1;
		@(posedge ref_clk) latch <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(hw_addr, straps);
		hw = straps;
		wr(hw, 1'b1, v[15:8], v[23:16], 1);
		wr(4'h0, 1'b1, v[15:8], v[23:16], 0);
		a = v[31:24] & 8'hfc;
		e = regval(a);
		rdlo(a);
		rdword({OP_RDHI, 1'b1, 4'hf, 8'hff}, e[15:0]);
		v = regval(a + 8'h04);
		rdlo(a + 8'h04);
		chk(r, e[31:16]);
		rdword({OP_RDHI, 1'b0, 4'h0, 8'h00}, v[15:0]);
		rdword({OP_RDHI, 1'b0, 4'h0, 8'h00}, v[31:16]);
		rdword(16'h0000, v[31:16]);
		rdword(16'h0000, 16'h0000);
		@(posedge ref_clk) imm <= 1'b0;
		e = regval(a ^ 8'h80);
		rdlo(a ^ 8'h80);
		rdword({OP_RDHI, 1'b1, 4'h0, 8'h00}, e[15:0]);
		rdword(16'h0000, e[31:16]);
		// second reset with select held low: the link must stay off
		@(posedge ref_clk) rst_n <= 1'b0;
		#2 spi_host_model_i.serial_select_n = 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({miso_oe, miso_out}, 2'b10);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(spi_enabled, 1'b0);
		chk(miso_oe, 1'b0);
		chk(hw_addr, HW_ADDR_RESET);
		#2 spi_host_model_i.serial_select_n = 1'b1;
		wr(4'h0, 1'b1, 8'h10, 8'h33, 0);
		report_and_stop();
	end
endmodule
